/* rtl/trace_compare_unit.sv */
// trace compare unit: trace capture, compare list and AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`default_nettype none
module trace_compare_unit (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic PROBE_STROBE,
  input wire logic PROBE_TRIG,
  input wire logic [trace_compare_pkg::DATA_W-1:0] PROBE_DATA,
  output logic TRACE_ACTIVE,
  output logic COMPARE_DONE
);
  import trace_compare_pkg::*;

  // probe synchroniser
  probe_type p1_r, p2_r;
  logic p3_strobe_r;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      p1_r <= '0;
      p2_r <= '0;
      p3_strobe_r <= 1'b0;
    end else begin
      p1_r <= {PROBE_STROBE, PROBE_TRIG, PROBE_DATA};
      p2_r <= p1_r;
      p3_strobe_r <= p2_r.strobe;
    end
  end
  logic sample;
  assign sample = p2_r.strobe & ~p3_strobe_r;

  // trace memory, no reset needed: contents are only read after a capture
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic mem_we;
  logic [MEM_AW-1:0] wptr_r, wptr_nxt;
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[wptr_r] <= p2_r.data;
    end
  end

  // control state
  state_type state_r, state_nxt;
  mode_type mode_r, mode_nxt;
  logic cont_r, cont_nxt;
  logic term_r, term_nxt;
  logic refused_r, refused_nxt;
  logic equal_r, equal_nxt;
  logic active_r, active_nxt;
  logic [POS_W-1:0] sel_r, sel_nxt;
  logic [DATA_W-1:0] care_r, care_nxt;
  logic [LIST_MAX-1:0] diff_r, diff_nxt;
  logic [MEM_AW-1:0] trig_addr_r, trig_addr_nxt;
  logic [POS_W-1:0] post_cnt_r, post_cnt_nxt;
  entry_type entry_r [LIST_MAX];
  entry_type entry_nxt [LIST_MAX];

  // bus state
  logic [7:0] addr_r, addr_nxt;
  logic wr_r, wr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  // per-entry compare against the captured listing
  logic [LIST_MAX-1:0] mism, at_sel, free;
  logic [DATA_W-1:0] sel_line;
  assign sel_line = mem[MEM_AW'(trig_addr_r + sel_r)];
  genvar gi;
  generate
    for (gi = 0; gi < LIST_MAX; gi++) begin : g_ent
      logic [DATA_W-1:0] line;
      assign line = mem[MEM_AW'(trig_addr_r + entry_r[gi].pos)];
      assign mism[gi] = entry_r[gi].valid &
                        (|((line ^ entry_r[gi].ref_val) & entry_r[gi].care));
      assign at_sel[gi] = entry_r[gi].valid & (entry_r[gi].pos == sel_r);
      assign free[gi] = ~entry_r[gi].valid;
    end
  endgenerate

  logic [CNT_W-1:0] count;
  always_comb begin
    count = '0;
    for (int i = 0; i < LIST_MAX; i++) begin
      count = count + CNT_W'(entry_r[i].valid);
    end
  end

  // bus decode
  logic take, ctrl_wr;
  logic cmd_run, cmd_stop, cmd_insert, cmd_delete, cmd_clear;
  assign take = HSEL & HREADY & HTRANS[1];
  assign ctrl_wr = wr_r & (addr_r == OFS_CTRL);
  assign cmd_run = ctrl_wr & HWDATA[CTRL_RUN_BIT];
  assign cmd_stop = ctrl_wr & HWDATA[CTRL_STOP_BIT];
  assign cmd_insert = ctrl_wr & HWDATA[CTRL_INSERT_BIT];
  assign cmd_delete = ctrl_wr & HWDATA[CTRL_DELETE_BIT];
  assign cmd_clear = ctrl_wr & HWDATA[CTRL_CLEAR_BIT];

  always_comb begin
    addr_nxt = addr_r;
    wr_nxt = take & HWRITE;
    hrdata_nxt = 32'h0000_0000;
    if (take) begin
      addr_nxt = HADDR[7:0];
    end
    if (take & ~HWRITE) begin
      case (HADDR[7:0])
        OFS_CTRL: hrdata_nxt[CTRL_MODE_LSB +: 2] = mode_r;
        OFS_SEL: hrdata_nxt[POS_W-1:0] = sel_r;
        OFS_CARE: hrdata_nxt[DATA_W-1:0] = care_r;
        OFS_STATUS: begin
          hrdata_nxt[STAT_ACTIVE_BIT] = active_r;
          hrdata_nxt[STAT_CONT_BIT] = cont_r;
          hrdata_nxt[STAT_TERM_BIT] = term_r;
          hrdata_nxt[STAT_FULL_BIT] = ~|free;
          hrdata_nxt[STAT_REFUSED_BIT] = refused_r;
          hrdata_nxt[STAT_EQUAL_BIT] = equal_r;
          hrdata_nxt[STAT_COUNT_LSB +: CNT_W] = count;
        end
        OFS_DIFF: hrdata_nxt[LIST_MAX-1:0] = diff_r;
        OFS_LINE: hrdata_nxt[DATA_W-1:0] = sel_line;
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end
  // zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_r;

  // control next state
  logic stop_cond;
  int slot;
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    cont_nxt = cont_r;
    term_nxt = term_r;
    refused_nxt = refused_r;
    equal_nxt = equal_r;
    sel_nxt = sel_r;
    care_nxt = care_r;
    diff_nxt = diff_r;
    trig_addr_nxt = trig_addr_r;
    post_cnt_nxt = post_cnt_r;
    wptr_nxt = wptr_r;
    entry_nxt = entry_r;
    slot = -1;
    mem_we = sample & ((state_r == ST_PRE) | (state_r == ST_POST));
    stop_cond = ((mode_r == MODE_UNTIL_EQ) & ~|mism) | ((mode_r == MODE_UNTIL_NE) & |mism);
    if (mem_we) begin
      wptr_nxt = wptr_r + 6'h01;
    end
    case (state_r)
      ST_IDLE: state_nxt = ST_IDLE;
      ST_PRE: begin
        if (sample & p2_r.trig) begin
          trig_addr_nxt = wptr_r;
          post_cnt_nxt = POST_LINES;
          state_nxt = ST_POST;
        end
      end
      ST_POST: begin
        if (sample) begin
          post_cnt_nxt = post_cnt_r - 6'h01;
          if (post_cnt_r == POST_LAST) begin
            state_nxt = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        diff_nxt = mism;
        equal_nxt = ~|mism;
        if (cont_r & stop_cond) begin
          state_nxt = ST_IDLE;
          term_nxt = 1'b1;
          cont_nxt = 1'b0;
        end else if (cont_r) begin
          state_nxt = ST_PRE;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (wr_r & (addr_r == OFS_SEL)) begin
      sel_nxt = HWDATA[POS_W-1:0];
    end
    if (wr_r & (addr_r == OFS_CARE)) begin
      care_nxt = HWDATA[DATA_W-1:0];
    end
    if (ctrl_wr) begin
      mode_nxt = mode_type'(HWDATA[CTRL_MODE_LSB +: 2]);
    end
    if (cmd_run) begin
      cont_nxt = (mode_type'(HWDATA[CTRL_MODE_LSB +: 2]) != MODE_OFF);
      term_nxt = 1'b0;
      state_nxt = ST_PRE;
    end else if (cmd_stop) begin
      cont_nxt = 1'b0;
      if (state_r == ST_IDLE) begin
        state_nxt = ST_PRE;
      end
    end
    if (cmd_clear) begin
      for (int i = 0; i < LIST_MAX; i++) begin
        entry_nxt[i].valid = 1'b0;
      end
      refused_nxt = 1'b0;
    end else if (cmd_insert & (state_r == ST_IDLE)) begin
      for (int i = LIST_MAX - 1; i >= 0; i--) begin
        if (free[i]) begin
          slot = i;
        end
      end
      for (int i = LIST_MAX - 1; i >= 0; i--) begin
        if (at_sel[i]) begin
          slot = i;
        end
      end
      if (slot < 0) begin
        refused_nxt = 1'b1;
      end else begin
        entry_nxt[slot] = '{valid: 1'b1, pos: sel_r, ref_val: sel_line, care: care_r};
        refused_nxt = 1'b0;
      end
    end else if (cmd_delete) begin
      for (int i = 0; i < LIST_MAX; i++) begin
        if (at_sel[i]) begin
          entry_nxt[i].valid = 1'b0;
        end
      end
    end
    active_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      mode_r <= MODE_OFF;
      cont_r <= 1'b0;
      term_r <= 1'b0;
      refused_r <= 1'b0;
      equal_r <= 1'b0;
      active_r <= 1'b0;
      sel_r <= SEL_RST;
      care_r <= CARE_RST;
      diff_r <= '0;
      trig_addr_r <= '0;
      post_cnt_r <= '0;
      wptr_r <= '0;
      for (int i = 0; i < LIST_MAX; i++) begin
        entry_r[i] <= '0;
      end
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      cont_r <= cont_nxt;
      term_r <= term_nxt;
      refused_r <= refused_nxt;
      equal_r <= equal_nxt;
      active_r <= active_nxt;
      sel_r <= sel_nxt;
      care_r <= care_nxt;
      diff_r <= diff_nxt;
      trig_addr_r <= trig_addr_nxt;
      post_cnt_r <= post_cnt_nxt;
      wptr_r <= wptr_nxt;
      entry_r <= entry_nxt;
    end
  end
  assign TRACE_ACTIVE = active_r;
  assign COMPARE_DONE = term_r;

  chk_full_refuse: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (cmd_insert & ~cmd_clear & (state_r == ST_IDLE) & ~|free & ~|at_sel)
    |=> refused_r & (count == $past(count)))
    else $error("insert into full list not refused");
  chk_diff_only_check: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (state_r != ST_CHECK) |=> $stable(diff_r))
    else $error("difference flags moved outside a check");
  chk_eq_stop: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (state_r == ST_CHECK & cont_r & mode_r == MODE_UNTIL_EQ & ~|mism & ~ctrl_wr)
    |=> (state_r == ST_IDLE) & term_r & ~cont_r & equal_r)
    else $error("until-equal did not stop on a matching trace");
  chk_ne_stop: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (state_r == ST_CHECK & cont_r & mode_r == MODE_UNTIL_NE & |mism & ~ctrl_wr)
    |=> (state_r == ST_IDLE) & term_r & ~equal_r)
    else $error("until-not-equal did not stop on a differing trace");
  chk_restart: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (state_r == ST_CHECK & cont_r & ~stop_cond & ~ctrl_wr) |=> (state_r == ST_PRE) & ~term_r)
    else $error("continuous compare did not restart");
  chk_stop_single: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (cmd_stop & ~cmd_run & state_r == ST_IDLE) |=> ~cont_r & (state_r == ST_PRE) & active_r)
    else $error("stop did not start a single trace");
  chk_masked_equal: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (state_r == ST_CHECK & entry_r[0].valid &
     ~|((g_ent[0].line ^ entry_r[0].ref_val) & entry_r[0].care)) |=> ~diff_r[0])
    else $error("masked or equal line was flagged");
  chk_insert_copy: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (cmd_insert & ~cmd_clear & state_r == ST_IDLE & at_sel[0])
    |=> entry_r[0].valid & (entry_r[0].ref_val == $past(sel_line))
        & (entry_r[0].pos == $past(sel_r)))
    else $error("insert did not copy the selected line");
  chk_delete_one: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (cmd_delete & ~cmd_insert & ~cmd_clear & at_sel[0] & ~at_sel[1] & entry_r[1].valid)
    |=> ~entry_r[0].valid & entry_r[1].valid)
    else $error("delete touched the wrong entry");
  chk_flag_diff: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (state_r == ST_CHECK & mism[0]) |=> diff_r[0] & ~equal_r)
    else $error("differing line not flagged");
endmodule // trace_compare_unit
`default_nettype wire

/* rtl/trace_compare_pkg.sv */
// constants, types and register map of the trace compare unit
`default_nettype none
package trace_compare_pkg;
  localparam int DATA_W = 16;
  localparam int LIST_MAX = 16;
  localparam int MEM_AW = 6;
  localparam int POS_W = 6;
  localparam int CNT_W = 5;
  localparam logic [POS_W-1:0] POST_LINES = 6'h1F;
  localparam logic [POS_W-1:0] POST_LAST = 6'h01;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_CARE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DIFF = 8'h10;
  localparam logic [7:0] OFS_LINE = 8'h14;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_INSERT_BIT = 2;
  localparam int CTRL_DELETE_BIT = 3;
  localparam int CTRL_CLEAR_BIT = 4;
  localparam int CTRL_MODE_LSB = 8;

  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_CONT_BIT = 1;
  localparam int STAT_TERM_BIT = 2;
  localparam int STAT_FULL_BIT = 3;
  localparam int STAT_REFUSED_BIT = 4;
  localparam int STAT_EQUAL_BIT = 5;
  localparam int STAT_COUNT_LSB = 8;

  localparam logic [POS_W-1:0] SEL_RST = 6'h00;
  localparam logic [DATA_W-1:0] CARE_RST = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_UNTIL_EQ = 2'h1,
    MODE_UNTIL_NE = 2'h2
  } mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PRE = 2'h1,
    ST_POST = 2'h3,
    ST_CHECK = 2'h2
  } state_type;

  typedef struct packed {
    logic valid;
    logic [POS_W-1:0] pos;
    logic [DATA_W-1:0] ref_val;
    logic [DATA_W-1:0] care;
  } entry_type;

  typedef struct packed {
    logic strobe;
    logic trig;
    logic [DATA_W-1:0] data;
  } probe_type;
endpackage
`default_nettype wire

/* bench/target_model.sv */
// probed target model: repeating 64-line state flow with optional faulty line
`default_nettype none
module target_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bad_en,
  input wire logic [trace_compare_pkg::POS_W-1:0] bad_line,
  output trace_compare_pkg::probe_type probe
);
  timeunit 1ns;
  timeprecision 1ps;
  import trace_compare_pkg::*;
  logic [9:0] t;
  logic [5:0] ln;
  // slot k of the frame carries line k-32, trigger on line 0
  assign ln = t[8:3] ^ 6'h20;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t <= 10'h000;
      probe <= '0;
    end else begin
      t <= (t == 10'h20F) ? 10'h000 : t + 10'h001;
      if (!t[9]) begin
        // data held a full 8-cycle line, strobe rises mid-line
        probe.strobe <= t[2];
        probe.trig <= (ln == 6'h00);
        probe.data <= 16'h5A00 ^ {10'h000, ln} ^ ((bad_en && ln == bad_line) ? 16'h0100 : 16'h0000);
      end else begin
        // strobe still between frames, data lines not held
        probe.strobe <= 1'b0;
        probe.trig <= 1'b0;
        probe.data <= ~probe.data;
      end
    end
  end
endmodule // target_model
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench of the trace compare unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import trace_compare_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, trace_active, compare_done;
  logic [31:0] hrdata;
  logic bad_en = 1'b0;
  logic [POS_W-1:0] bad_line = 6'h02;
  probe_type probe;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;

  target_model partner (.clk(clk), .rst_n(rst_n), .bad_en(bad_en), .bad_line(bad_line),
    .probe(probe));
  trace_compare_unit DUT (.CLK_SYS(clk), .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .PROBE_STROBE(probe.strobe),
    .PROBE_TRIG(probe.trig), .PROBE_DATA(probe.data), .TRACE_ACTIVE(trace_active),
    .COMPARE_DONE(compare_done));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // entered just after a rising edge, leaves just after one
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic ins(input logic [31:0] sel, input logic [31:0] care);
    wr(OFS_SEL, sel);
    wr(OFS_CARE, care);
    wr(OFS_CTRL, 32'h4);
  endtask

  task automatic wait_trace();
    int i;
    i = 0;
    while (trace_active !== 1'b1 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    while (trace_active !== 1'b0 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    chk("trace end", {31'h0, trace_active}, 32'h0);
  endtask

  // skip the edges where a fresh RUN still clears the old flag
  task automatic wait_done(input int lim, input logic exp);
    int i;
    i = 0;
    repeat (2) @(posedge clk);
    while (compare_done !== 1'b1 && i < lim) begin
      @(posedge clk);
      i++;
    end
    chk("done", {31'h0, compare_done}, {31'h0, exp});
  endtask

  task automatic t_reset();
    logic [7:0] a[6] = '{OFS_CTRL, OFS_SEL, OFS_CARE, OFS_STATUS, OFS_DIFF, 8'h1C};
    logic [31:0] e[6] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
    logic [31:0] r;
    wr(8'h1C, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      rd(a[i], r);
      chk("reset value", r, e[i]);
    end
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic t_single();
    logic [31:0] r;
    wr(OFS_CTRL, 32'h2);
    wait_trace();
    wr(OFS_SEL, 32'h2);
    rd(OFS_LINE, r);
    chk("line +2", r, 32'h5A02);
    wr(OFS_SEL, 32'h1F);
    rd(OFS_LINE, r);
    chk("line +31", r, 32'h5A1F);
  endtask

  task automatic t_insert();
    logic [31:0] r;
    ins(32'h2, 32'hFFFF);
    ins(32'h1F, 32'hFEFF);
    rd(OFS_STATUS, r);
    chk("count", r & 32'h1F18, 32'h0200);
  endtask

  task automatic t_until_ne();
    logic [31:0] r;
    bad_line <= 6'h1F;
    bad_en <= 1'b1;
    wr(OFS_CTRL, 32'h201);
    wait_done(2400, 1'b0);
    chk("active", {31'h0, trace_active}, 32'h1);
    bad_line <= 6'h02;
    wait_done(3000, 1'b1);
    rd(OFS_DIFF, r);
    chk("diff ne", r, 32'h1);
    rd(OFS_STATUS, r);
    chk("status ne", r & 32'h1F05, 32'h0204);
  endtask

  task automatic t_until_eq();
    logic [31:0] r;
    wr(OFS_CTRL, 32'h101);
    wait_done(2400, 1'b0);
    bad_en <= 1'b0;
    wait_done(3000, 1'b1);
    rd(OFS_DIFF, r);
    chk("diff eq", r, 32'h0);
    rd(OFS_STATUS, r);
    chk("status eq", r & 32'h25, 32'h24);
  endtask

  task automatic t_delete();
    logic [31:0] r;
    wr(OFS_SEL, 32'h2);
    wr(OFS_CTRL, 32'h8);
    bad_en <= 1'b1;
    wr(OFS_CTRL, 32'h2);
    wait_trace();
    rd(OFS_DIFF, r);
    chk("diff del", r, 32'h0);
    rd(OFS_STATUS, r);
    chk("count del", r & 32'h1F00, 32'h0100);
  endtask

  task automatic t_stop();
    logic [31:0] r;
    bad_en <= 1'b0;
    wr(OFS_CTRL, 32'h201);
    repeat (600) @(posedge clk);
    wr(OFS_CTRL, 32'h202);
    wait_trace();
    chk("no done", {31'h0, compare_done}, 32'h0);
    rd(OFS_STATUS, r);
    chk("single", r & 32'h3, 32'h0);
  endtask

  task automatic t_full();
    logic [31:0] r;
    wr(OFS_CTRL, 32'h10);
    for (int i = 0; i < 16; i++) begin
      ins(32'h20 + 32'(2 * i), 32'hFFFF);
    end
    ins(32'h1F, 32'hFFFF);
    rd(OFS_STATUS, r);
    chk("full", r & 32'h1F18, 32'h1018);
    ins(32'h20, 32'h00FF);
    rd(OFS_STATUS, r);
    chk("overwrite", r & 32'h1F18, 32'h1008);
  endtask

  // reset in the middle of a continuous run, then one plain single run
  task automatic t_midreset();
    logic [31:0] r;
    wr(OFS_CTRL, 32'h201);
    repeat (300) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("active in reset", {31'h0, trace_active}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_STATUS, r);
    chk("status after reset", r, 32'h0);
    rd(OFS_CTRL, r);
    chk("mode after reset", r, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wait_trace();
    chk("single run done", {31'h0, compare_done}, 32'h0);
    rd(OFS_STATUS, r);
    chk("single run status", r & 32'h27, 32'h20);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ceiling well above the roughly 9500 cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_single();
    t_insert();
    t_until_ne();
    t_until_eq();
    t_delete();
    t_stop();
    t_full();
    t_midreset();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
